// ---- hw/pks_device.sv ----
// Module end: key and reset timing, power state, card slots
`timescale 1ns/1ps
`include "pks_consts.svh"
module pks_device #(
	// Clock cycles per millisecond tick
	parameter int unsigned MS_CYCLES = `PKS_MS_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	pks_link_if.dev link,
	input wire logic i_power_off_command,
	input wire logic i_card_detect_config_command,
	input wire logic i_card_detect_enable,
	input wire logic [1:0] i_card_detect_active_high,
	input wire logic i_card_slot_select_command,
	input wire logic i_card_slot,
	input wire logic [1:0] i_card_insert_detect,
	input wire logic [1:0] i_card_low_voltage_ok,
	output logic o_status,
	output logic o_powered,
	output logic o_reset_pulse,
	output logic o_card_slot,
	output logic [1:0] o_card_present,
	output logic [1:0] o_card_hotplug_event,
	output pks_pkg::pks_card_class_t o_card_class [2]
);
	import pks_pkg::*;
	// ==========================================================
	// Millisecond tick
	logic [`PKS_MS_CNT_W-1:0] ms_cnt;
	logic ms_tick;
	wire ms_wrap = (ms_cnt == `PKS_MS_CNT_W'(MS_CYCLES - 1));
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ms_cnt <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_cnt <= ms_wrap ? '0 : ms_cnt + 1'b1;
			ms_tick <= ms_wrap;
		end
	end
	function automatic logic [`PKS_DUR_W-1:0] sat_inc(input logic [`PKS_DUR_W-1:0] v);
		sat_inc = (&v) ? v : v + 1'b1;
	endfunction
	// ==========================================================
	// Pulse width counters
	logic [`PKS_DUR_W-1:0] key_ms, rst_ms, st_ms;
	logic rst_prev;
	wire key_low = !link.power_key_n;
	wire rst_low = !link.reset_n;
	wire rst_rise = rst_low == 1'b0 && rst_prev;
	wire rst_ok = rst_rise && rst_ms >= `PKS_RST_MIN_MS && rst_ms <= `PKS_RST_MAX_MS;
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			key_ms <= '0;
			rst_ms <= '0;
			rst_prev <= 1'b0;
		end else begin
			rst_prev <= rst_low;
			if (!key_low)
				key_ms <= '0;
			else if (ms_tick)
				key_ms <= sat_inc(key_ms);
			if (!rst_low)
				rst_ms <= '0;
			else if (ms_tick)
				rst_ms <= sat_inc(rst_ms);
		end
	end
	// ==========================================================
	// Power state machine
	pks_dev_state_t state, next_state;
	logic off_armed;
	always_comb begin
		next_state = state;
		case (state)
			PKS_OFF: begin
				if (link.supply_on && key_ms >= `PKS_ON_MS)
					next_state = PKS_BOOT;
			end
			PKS_BOOT: begin
				if (st_ms >= `PKS_BOOT_MS)
					next_state = PKS_ON;
			end
			PKS_ON: begin
				if (i_power_off_command)
					next_state = PKS_SHUT;
				else if (!off_armed && key_ms >= `PKS_OFF_MS)
					next_state = PKS_OFF_WAIT_REL;
			end
			PKS_OFF_WAIT_REL: begin
				if (!key_low)
					next_state = PKS_SHUT;
			end
			PKS_SHUT: begin
				if (st_ms >= `PKS_SHUT_MS)
					next_state = PKS_OFF;
			end
			default: next_state = PKS_OFF;
		endcase
		if (!link.supply_on)
			next_state = PKS_OFF;
		else if (rst_ok && state != PKS_OFF)
			next_state = PKS_BOOT;
	end
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= PKS_OFF;
			st_ms <= '0;
			off_armed <= 1'b1;
			o_status <= 1'b0;
			o_powered <= 1'b0;
			o_reset_pulse <= 1'b0;
		end else begin
			state <= next_state;
			if (next_state != state)
				st_ms <= '0;
			else if (ms_tick)
				st_ms <= sat_inc(st_ms);
			// Key still held from power-on must be released before it can turn off
			if (next_state == PKS_BOOT)
				off_armed <= 1'b1;
			else if (!key_low)
				off_armed <= 1'b0;
			o_status <= next_state == PKS_ON || next_state == PKS_OFF_WAIT_REL;
			o_powered <= next_state != PKS_OFF;
			o_reset_pulse <= rst_ok && state != PKS_OFF;
		end
	end
	assign link.status = o_status;
	// ==========================================================
	// Card slots
	wire card_rst = !o_powered;
	logic det_en;
	logic [1:0] det_pol, det_prev;
	logic [1:0] present;
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			det_en <= 1'b0;
			det_pol <= 2'b00;
			det_prev <= 2'b00;
			o_card_slot <= 1'b0;
			o_card_present <= 2'b00;
			o_card_hotplug_event <= 2'b00;
		end else if (card_rst) begin
			det_en <= 1'b0;
			o_card_slot <= 1'b0;
			o_card_present <= 2'b00;
			o_card_hotplug_event <= 2'b00;
			det_prev <= 2'b00;
		end else begin
			if (i_card_detect_config_command) begin
				det_en <= i_card_detect_enable;
				det_pol <= i_card_detect_active_high;
			end
			if (i_card_slot_select_command)
				o_card_slot <= i_card_slot;
			det_prev <= present;
			o_card_present <= present;
			o_card_hotplug_event <= det_en ? (present ^ det_prev) : 2'b00;
		end
	end
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_slot
			// Present when detect is disabled, else when detect level matches configured polarity
			assign present[g] = det_en ? (i_card_insert_detect[g] == det_pol[g]) : 1'b1;
			logic [`PKS_DUR_W-1:0] probe_ms;
			always_ff @(posedge i_sys_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					probe_ms <= '0;
					o_card_class[g] <= PKS_CLS_NONE;
				end else if (card_rst || o_card_slot != 1'(g) || !present[g]) begin
					probe_ms <= '0;
					o_card_class[g] <= PKS_CLS_NONE;
				end else if (o_card_class[g] == PKS_CLS_NONE) begin
					if (ms_tick)
						probe_ms <= sat_inc(probe_ms);
					if (probe_ms >= `PKS_CARD_PROBE_MS)
						o_card_class[g] <= i_card_low_voltage_ok[g] ? PKS_CLS_1V8 : PKS_CLS_3V0;
				end
			end
		end
	endgenerate
endmodule // pks_device

// ---- hw/pks_consts.svh ----
// Timing constants for the power key reset sequencer
`ifndef PKS_CONSTS_SVH
`define PKS_CONSTS_SVH
`define PKS_CLK_HZ 25000000
`define PKS_MS_CYCLES (`PKS_CLK_HZ / 1000)
`define PKS_MS_CNT_W 15
`define PKS_DUR_W 12
`define PKS_ON_MS 12'd500
`define PKS_OFF_MS 12'd800
`define PKS_RST_MIN_MS 12'd250
`define PKS_RST_MAX_MS 12'd600
`define PKS_SUPPLY_MS 12'd30
`define PKS_BOOT_MS 12'd100
`define PKS_SHUT_MS 12'd100
`define PKS_HOST_RST_MS 12'd400
`define PKS_CARD_PROBE_MS 12'd10
`endif

// ---- hw/pks_pkg.sv ----
// Types for the two ends of the power key reset sequencer, each state type used by one end only
package pks_pkg;
	typedef enum logic [2:0] {
		PKS_OFF,
		PKS_BOOT,
		PKS_ON,
		PKS_OFF_WAIT_REL,
		PKS_SHUT
	} pks_dev_state_t;
	typedef enum logic [2:0] {
		PKS_H_IDLE,
		PKS_H_SUPPLY,
		PKS_H_PRESS_ON,
		PKS_H_PRESS_OFF,
		PKS_H_WAIT_OFF,
		PKS_H_RESET
	} pks_host_state_t;
	typedef enum logic [1:0] {
		PKS_CLS_NONE,
		PKS_CLS_1V8,
		PKS_CLS_3V0
	} pks_card_class_t;
endpackage

// ---- hw/pks_link_if.sv ----
// Pins between the host and the module
`timescale 1ns/1ps
interface pks_link_if;
	logic power_key_n_o;
	logic power_key_n_oe;
	logic power_key_n;
	logic reset_n_o;
	logic reset_n_oe;
	logic reset_n;
	logic supply_on;
	logic status;
	// Open-drain key and reset with internal pull-up
	assign power_key_n = (power_key_n_oe && !power_key_n_o) ? 1'b0 : 1'b1;
	assign reset_n = (reset_n_oe && !reset_n_o) ? 1'b0 : 1'b1;
	modport dev (input power_key_n, input reset_n, input supply_on, output status);
	modport host (output power_key_n_o, output power_key_n_oe, output reset_n_o,
		output reset_n_oe, output supply_on, input status);
endinterface

// ---- hw/pks_host.sv ----
// Host end: supply control, power key and reset pulse generation
`timescale 1ns/1ps
`include "pks_consts.svh"
module pks_host #(
	// Clock cycles per millisecond tick
	parameter int unsigned MS_CYCLES = `PKS_MS_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	pks_link_if.host link,
	input wire logic i_turn_on,
	input wire logic i_turn_off,
	input wire logic i_hard_reset,
	input wire logic i_power_off_command_done,
	output logic o_busy,
	output logic o_module_on
);
	import pks_pkg::*;
	// ==========================================================
	// Millisecond tick
	logic [`PKS_MS_CNT_W-1:0] ms_cnt;
	logic ms_tick;
	wire ms_wrap = (ms_cnt == `PKS_MS_CNT_W'(MS_CYCLES - 1));
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ms_cnt <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_cnt <= ms_wrap ? '0 : ms_cnt + 1'b1;
			ms_tick <= ms_wrap;
		end
	end
	// ==========================================================
	// Sequencer
	pks_host_state_t state, next_state;
	logic [`PKS_DUR_W-1:0] t_ms;
	logic key_drive, rst_drive, supply;
	always_comb begin
		next_state = state;
		case (state)
			PKS_H_IDLE: begin
				if (i_turn_on && !link.status)
					next_state = PKS_H_SUPPLY;
				else if (i_turn_off && link.status)
					next_state = PKS_H_PRESS_OFF;
				else if (i_hard_reset && supply)
					next_state = PKS_H_RESET;
			end
			PKS_H_SUPPLY: begin
				if (t_ms >= `PKS_SUPPLY_MS)
					next_state = PKS_H_PRESS_ON;
			end
			PKS_H_PRESS_ON: begin
				if (t_ms >= `PKS_ON_MS && link.status)
					next_state = PKS_H_IDLE;
			end
			PKS_H_PRESS_OFF: begin
				if (t_ms >= `PKS_OFF_MS)
					next_state = PKS_H_WAIT_OFF;
			end
			PKS_H_WAIT_OFF: begin
				if (t_ms >= `PKS_SHUT_MS + `PKS_SHUT_MS)
					next_state = PKS_H_IDLE;
			end
			PKS_H_RESET: begin
				if (t_ms >= `PKS_HOST_RST_MS)
					next_state = PKS_H_IDLE;
			end
			default: next_state = PKS_H_IDLE;
		endcase
	end
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= PKS_H_IDLE;
			t_ms <= '0;
			key_drive <= 1'b0;
			rst_drive <= 1'b0;
			supply <= 1'b0;
			o_busy <= 1'b0;
			o_module_on <= 1'b0;
		end else begin
			state <= next_state;
			if (next_state != state)
				t_ms <= '0;
			else if (ms_tick && !(&t_ms))
				t_ms <= t_ms + 1'b1;
			key_drive <= next_state == PKS_H_PRESS_ON || next_state == PKS_H_PRESS_OFF;
			rst_drive <= next_state == PKS_H_RESET;
			if (next_state == PKS_H_SUPPLY)
				supply <= 1'b1;
			else if (state == PKS_H_WAIT_OFF && next_state == PKS_H_IDLE)
				supply <= 1'b0;
			else if (i_power_off_command_done && state == PKS_H_IDLE && !link.status)
				supply <= 1'b0;
			o_busy <= next_state != PKS_H_IDLE;
			o_module_on <= link.status;
		end
	end
	assign link.power_key_n_o = 1'b0;
	assign link.power_key_n_oe = key_drive;
	assign link.reset_n_o = 1'b0;
	assign link.reset_n_oe = rst_drive;
	assign link.supply_on = supply;
endmodule // pks_host

// ---- testbench/pks_link_props.sv ----
// Concurrent checks on the pins between host and module
`timescale 1ns/1ps
module pks_link_props (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic power_key_n_oe,
	input wire logic power_key_n,
	input wire logic reset_n_oe,
	input wire logic reset_n,
	input wire logic supply_on,
	input wire logic status
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	// ==========================================================
	// Assertions
	a_key_pull_up: assert property (!power_key_n_oe |-> power_key_n)
		else $error("key not high while undriven");
	a_reset_pull_up: assert property (!reset_n_oe |-> reset_n)
		else $error("reset not high while undriven");
	a_no_key_unpowered: assert property (!supply_on |-> power_key_n)
		else $error("key pressed without supply");
	a_key_held_to_status: assert property ($rose(power_key_n) |-> status)
		else $error("key released before status high");
	a_on_while_held: assert property (status && !power_key_n && supply_on |=> status)
		else $error("status fell while key held");
	a_off_after_release: assert property ($fell(status) |-> power_key_n)
		else $error("status fell with key low");
	a_supply_cut_safe: assert property ($fell(supply_on) |-> !status)
		else $error("supply cut while module on");
	a_reset_drops_on: assert property ($rose(reset_n) && status |-> ##[1:4] !status)
		else $error("hard reset did not drop status");
	// ==========================================================
	// Coverage
	c_power_up: cover property ($rose(status));
	c_power_down: cover property ($fell(status) && supply_on);
	c_hard_reset: cover property ($rose(reset_n));
endmodule // pks_link_props

// ---- testbench/tb.sv ----
// Testbench joining host and module ends
`timescale 1ns/1ps
`include "pks_consts.svh"
module tb;
	import pks_pkg::*;
	// Shortened millisecond tick keeps the run short
	localparam int MS = 10;
	logic sys_clk, rstn, turn_on, turn_off, hard_reset, pocd, poc, cdc, cde, css, slot;
	logic [1:0] cdah, ins, lvok, present, hp_ev;
	logic status_o, powered, rst_pulse, card_slot, busy, mod_on;
	pks_card_class_t cls [2];
	int n_errors = 0;
	int comparisons = 0;
	// ==========================================================
	// Ends and checker
	pks_link_if link ();
	pks_device #(.MS_CYCLES(MS)) u_pks_device (.i_sys_clk(sys_clk), .i_rstn(rstn), .link(link),
		.i_power_off_command(poc), .i_card_detect_config_command(cdc),
		.i_card_detect_enable(cde), .i_card_detect_active_high(cdah),
		.i_card_slot_select_command(css), .i_card_slot(slot), .i_card_insert_detect(ins),
		.i_card_low_voltage_ok(lvok), .o_status(status_o), .o_powered(powered),
		.o_reset_pulse(rst_pulse), .o_card_slot(card_slot), .o_card_present(present),
		.o_card_hotplug_event(hp_ev), .o_card_class(cls));
	pks_host #(.MS_CYCLES(MS)) u_pks_host (.i_sys_clk(sys_clk), .i_rstn(rstn), .link(link),
		.i_turn_on(turn_on),
		.i_turn_off(turn_off), .i_hard_reset(hard_reset), .i_power_off_command_done(pocd),
		.o_busy(busy), .o_module_on(mod_on));
	pks_link_props u_props (.i_sys_clk(sys_clk), .i_rstn(rstn),
		.power_key_n_oe(link.power_key_n_oe), .power_key_n(link.power_key_n),
		.reset_n_oe(link.reset_n_oe), .reset_n(link.reset_n), .supply_on(link.supply_on),
		.status(link.status));
	// ==========================================================
	// Tasks
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic end_sim();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge sys_clk) s = 1'b1;
		@(negedge sys_clk) s = 1'b0;
	endtask
	task automatic wait_on(input int sel, input logic v, input int cyc);
		logic s;
		for (int i = 0; i < cyc; i++) begin
			@(negedge sys_clk);
			case (sel)
				0: s = link.status;
				1: s = rst_pulse;
				2: s = busy;
				default: s = hp_ev[1];
			endcase
			if (s === v) return;
		end
		n_errors++;
		$display("MISMATCH wait%0d exp %b seen timeout", sel, v);
		end_sim();
	endtask
	// ==========================================================
	// Sequence
	initial begin
		{rstn, turn_on, turn_off, hard_reset, pocd, poc, cdc, cde, css, slot} = '0;
		{cdah, ins, lvok} = '0;
		repeat (4) @(negedge sys_clk);
		rstn = 1'b1;
		chk("supply", 2'(link.supply_on), 2'h0);
		chk("key", 2'(link.power_key_n), 2'h1);
		pulse(turn_on);
		wait_on(2, 1'b0, 700 * MS);
		chk("status", 2'(link.status), 2'h1);
		chk("key_rel", 2'(link.power_key_n), 2'h1);
		chk("mod_on", 2'(mod_on), 2'h1);
		lvok = 2'b10;
		slot = 1'b1;
		pulse(css);
		repeat (11 * MS) @(negedge sys_clk);
		chk("slot", 2'(card_slot), 2'h1);
		chk("cls0", cls[0], PKS_CLS_NONE);
		chk("cls1", cls[1], PKS_CLS_1V8);
		chk("present", present, 2'h3);
		slot = 1'b0;
		pulse(css);
		repeat (11 * MS) @(negedge sys_clk);
		chk("cls0b", cls[0], PKS_CLS_3V0);
		chk("cls1b", cls[1], PKS_CLS_NONE);
		cde = 1'b1;
		cdah = 2'b10;
		pulse(cdc);
		repeat (2 * MS) @(negedge sys_clk);
		chk("det_lvl", present, 2'h1);
		ins = 2'b10;
		wait_on(3, 1'b1, 2 * MS);
		chk("det_in", present, 2'h3);
		pulse(hard_reset);
		wait_on(1, 1'b1, 500 * MS);
		repeat (5) @(negedge sys_clk);
		chk("rst_st", 2'(link.status), 2'h0);
		wait_on(0, 1'b1, 150 * MS);
		wait_on(2, 1'b0, 200 * MS);
		pulse(turn_off);
		wait_on(0, 1'b0, 1000 * MS);
		chk("off_key", 2'(link.power_key_n), 2'h1);
		wait_on(2, 1'b0, 400 * MS);
		chk("off_sup", 2'(link.supply_on), 2'h0);
		chk("off_pwr", 2'(powered), 2'h0);
		pulse(turn_on);
		wait_on(2, 1'b0, 700 * MS);
		pulse(poc);
		wait_on(0, 1'b0, 200 * MS);
		repeat (110 * MS) @(negedge sys_clk);
		chk("cmd_key", 2'(link.power_key_n), 2'h1);
		chk("cmd_pwr", 2'(powered), 2'h0);
		pulse(pocd);
		repeat (3) @(negedge sys_clk);
		chk("cmd_sup", 2'(link.supply_on), 2'h0);
		end_sim();
	end
endmodule // tb
